// ==== design/ber_params.svh ====
`ifndef BER_PARAMS_SVH
`define BER_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_TX_START    16'h00C8
`define OFS_TX_LENGTH   16'h00C9
`define OFS_RX_LENGTH   16'h00CA
`define OFS_RX_START    16'h00CB
`define OFS_ERR_COUNT   16'h00CC
`define OFS_TEST_CTRL   16'h00B0
`define OFS_IRQ_STATUS  16'h00B1
`define OFS_IRQ_CLEAR   16'h00B2
`define OFS_IRQ_ENABLE  16'h00B3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CHAN_LSB        0
`define CHAN_MSB        8
`define STREAM_LSB      9
`define STREAM_MSB      13
`define LEN_MSB         8
`define CTRL_TX_EN      0
`define CTRL_RX_EN      1
`define CTRL_CNT_CLR    2
`define EVT_ERROR       0
`define EVT_SATURATE    1
`define EVT_FRAME_DONE  2

// ----------------------------------------
// Reset values and count saturation limit
// ----------------------------------------
`define RST_REG16       16'h0000
`define RST_EVT         3'h0
`define PRBS_SEED       15'h7FFF
`define COUNT_MAX       16'hFFFF

`endif

// ==== design/ber_pkg.sv ====
package ber_pkg;

  // Time slot presented by the frame engine
  typedef struct packed {
    logic [4:0] stream;
    logic [8:0] channel;
  } slot_t;

  // Received byte with its slot
  typedef struct packed {
    logic       valid;
    slot_t      slot;
    logic [7:0] data;
  } rx_beat_t;

  // Complete block state
  typedef struct packed {
    logic [15:0] tx_start;
    logic [15:0] tx_length;
    logic [15:0] rx_length;
    logic [15:0] rx_start;
    logic [15:0] err_count;
    logic [1:0]  ctrl;
    logic [2:0]  evt_status;
    logic [2:0]  evt_enable;
    logic [14:0] tx_prbs;
    logic [14:0] rx_prbs;
    logic        in_rx_win;
    logic        tx_insert;
    logic [7:0]  tx_byte;
    logic [15:0] rd_data;
  } state_t;

endpackage

// ==== design/backplane_ber_test_unit.sv ====
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "ber_params.svh"

// Notes on behaviour
// - Send pattern on transmit length plus one channels from start send channel.
// - Compare on receive length plus one channels from start receive channel.
// - Checked input stream comes from bits 13:9 of start receive register.
// - Comparison begins at channel in bits 8:0 of start receive register.
// - Error count is sixteen bits, read-only; writes leave it unchanged.
// - Count sticks at FFFF until the count clear bit is written.
// - Send stream from start send bits 13:9, start channel from bits 8:0.

module backplane_ber_test_unit
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // Register port
  input  wire logic [15:0]         reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [15:0]         reg_rdata,
  // Frame timing
  input  wire logic                frame_start,
  // Transmit slot request and answer
  input  wire logic                tx_slot_req,
  input  wire ber_pkg::slot_t      tx_slot,
  output logic                     tx_slot_insert,
  output logic      [7:0]          tx_slot_byte,
  // Received slots
  input  wire ber_pkg::rx_beat_t   rx_beat,
  // Interrupt
  output logic                     irq
);

  import ber_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Advance the x^15+x^14+1 sequence by eight bits
  function automatic logic [14:0] prbs_step8(input logic [14:0] s);
    logic [14:0] r;
    r = s;
    for (int i = 0; i < 8; i++)
    begin
      r = {r[13:0], r[14] ^ r[13]};
    end
    return r;
  endfunction

  // Byte taken from the sequence state
  function automatic logic [7:0] prbs_byte(input logic [14:0] s);
    return s[14:7];
  endfunction

  // Slot inside a run of length+1 channels from start
  function automatic logic in_run(input slot_t      slot,
                                  input logic [15:0] start,
                                  input logic [15:0] length);
    logic [9:0] ofs;
    ofs = {1'b0, slot.channel} - {1'b0, start[`CHAN_MSB:`CHAN_LSB]};
    return (slot.stream == start[`STREAM_MSB:`STREAM_LSB])
        && (slot.channel >= start[`CHAN_MSB:`CHAN_LSB])
        && (ofs <= {1'b0, length[`LEN_MSB:0]});
  endfunction

  // Number of set bits in a byte
  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // Saturating add of a bit count
  function automatic logic [15:0] sat_add(input logic [15:0] a,
                                          input logic [3:0]  b);
    logic [16:0] s;
    s = {1'b0, a} + {13'h0, b};
    return s[16] ? `COUNT_MAX : s[15:0];
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_t     st_q;
  state_t     st_d;

  logic [7:0] rx_diff;
  logic [3:0] rx_errs;
  logic       rx_hit;
  logic       tx_hit;
  logic       cnt_clr;
  logic [2:0] evt_set;
  logic [2:0] evt_clr;
  logic [15:0] cnt_base;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_d     = st_q;
    rx_diff  = 8'h00;
    rx_errs  = 4'h0;
    evt_set  = 3'h0;
    evt_clr  = 3'h0;
    cnt_clr  = 1'b0;
    cnt_base = st_q.err_count;

    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        `OFS_TX_START:   st_d.tx_start  = reg_wdata;
        `OFS_TX_LENGTH:  st_d.tx_length = reg_wdata;
        `OFS_RX_LENGTH:  st_d.rx_length = reg_wdata;
        `OFS_RX_START:   st_d.rx_start  = reg_wdata;
        `OFS_TEST_CTRL:
        begin
          st_d.ctrl = {reg_wdata[`CTRL_RX_EN], reg_wdata[`CTRL_TX_EN]};
          cnt_clr   = reg_wdata[`CTRL_CNT_CLR];
        end
        `OFS_IRQ_CLEAR:  evt_clr = reg_wdata[2:0];
        `OFS_IRQ_ENABLE: st_d.evt_enable = reg_wdata[2:0];
        default:         st_d.rd_data = st_d.rd_data;
      endcase
    end

    // Register reads, data stand one cycle
    st_d.rd_data = 16'h0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `OFS_TX_START:   st_d.rd_data = st_q.tx_start;
        `OFS_TX_LENGTH:  st_d.rd_data = st_q.tx_length;
        `OFS_RX_LENGTH:  st_d.rd_data = st_q.rx_length;
        `OFS_RX_START:   st_d.rd_data = st_q.rx_start;
        `OFS_ERR_COUNT:  st_d.rd_data = st_q.err_count;
        `OFS_TEST_CTRL:  st_d.rd_data = {14'h0, st_q.ctrl};
        `OFS_IRQ_STATUS: st_d.rd_data = {13'h0, st_q.evt_status};
        `OFS_IRQ_ENABLE: st_d.rd_data = {13'h0, st_q.evt_enable};
        default:         st_d.rd_data = 16'h0000;
      endcase
    end

    // Transmit run, one byte per channel
    st_d.tx_insert = 1'b0;
    st_d.tx_byte   = 8'h00;
    if (tx_hit)
    begin
      st_d.tx_insert = 1'b1;
      st_d.tx_byte   = prbs_byte(st_q.tx_prbs);
      st_d.tx_prbs   = prbs_step8(st_q.tx_prbs);
    end

    if (rx_hit)
    begin
      rx_diff      = rx_beat.data ^ prbs_byte(st_q.rx_prbs);
      rx_errs      = ones8(rx_diff);
      st_d.rx_prbs = prbs_step8(st_q.rx_prbs);
      if (rx_errs != 4'h0)
      begin
        evt_set[`EVT_ERROR] = 1'b1;
      end
    end

    if (cnt_clr)
    begin
      cnt_base     = `RST_REG16;
      st_d.tx_prbs = `PRBS_SEED;
      st_d.rx_prbs = `PRBS_SEED;
    end
    st_d.err_count = sat_add(cnt_base, rx_errs);
    if (rx_hit && (rx_errs != 4'h0) && (st_d.err_count == `COUNT_MAX)
        && (st_q.err_count != `COUNT_MAX))
    begin
      evt_set[`EVT_SATURATE] = 1'b1;
    end

    // Receive window end per frame
    if (rx_hit)
    begin
      st_d.in_rx_win = 1'b1;
    end
    if (frame_start)
    begin
      st_d.in_rx_win = 1'b0;
      if (st_q.in_rx_win)
      begin
        evt_set[`EVT_FRAME_DONE] = 1'b1;
      end
    end

    // Sticky events, set beats clear
    st_d.evt_status = (st_q.evt_status & ~evt_clr) | evt_set;
  end

  // ----------------------------------------
  // Window decode
  // ----------------------------------------

  assign tx_hit = tx_slot_req && st_q.ctrl[`CTRL_TX_EN]
               && in_run(tx_slot, st_q.tx_start, st_q.tx_length);

  // Receive run of length plus one
  assign rx_hit = rx_beat.valid && st_q.ctrl[`CTRL_RX_EN]
               && in_run(rx_beat.slot, st_q.rx_start, st_q.rx_length);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q.tx_start   <= `RST_REG16;
      st_q.tx_length  <= `RST_REG16;
      st_q.rx_length  <= `RST_REG16;
      st_q.rx_start   <= `RST_REG16;
      st_q.err_count  <= `RST_REG16;
      st_q.ctrl       <= 2'h0;
      st_q.evt_status <= `RST_EVT;
      st_q.evt_enable <= `RST_EVT;
      st_q.tx_prbs    <= `PRBS_SEED;
      st_q.rx_prbs    <= `PRBS_SEED;
      st_q.in_rx_win  <= 1'b0;
      st_q.tx_insert  <= 1'b0;
      st_q.tx_byte    <= 8'h00;
      st_q.rd_data    <= `RST_REG16;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata      = st_q.rd_data;
  assign tx_slot_insert = st_q.tx_insert;
  assign tx_slot_byte   = st_q.tx_byte;
  assign irq            = |(st_q.evt_status & st_q.evt_enable);

endmodule

// ==== sim/backplane_ber_test_unit_props.sv ====
`timescale 1ns/1ps
module ber_props
(
  // Clock and reset
  input wire logic           sys_clk,
  input wire logic           rst_n,
  // Register port
  input wire logic [15:0]    reg_addr,
  input wire logic [15:0]    reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [15:0]    reg_rdata,
  // Transmit slots
  input wire logic           tx_slot_req,
  input wire ber_pkg::slot_t tx_slot,
  input wire logic           tx_slot_insert,
  input wire logic [7:0]     tx_slot_byte
);
  import ber_pkg::*;
  logic [15:0] st_q;
  logic [15:0] ln_q;
  logic        en_q;
  logic        win;
  // Shadow of send setup
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      st_q <= 16'h0000;
      ln_q <= 16'h0000;
      en_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 16'h00C8) st_q <= reg_wdata;
      if (reg_addr == 16'h00C9) ln_q <= reg_wdata;
      if (reg_addr == 16'h00B0) en_q <= reg_wdata[0];
    end
  assign win = en_q && tx_slot.stream == st_q[13:9] && tx_slot.channel >= st_q[8:0]
               && {1'b0, tx_slot.channel} <= {1'b0, st_q[8:0]} + {1'b0, ln_q[8:0]};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_clear_reads_zero: assert property (s_rd(16'h00B2) |=> reg_rdata == 16'h0000)
    else $error("clear register read not zero");
  a_start_read: assert property (s_rd(16'h00C8) |=> reg_rdata == $past(st_q))
    else $error("send start readback wrong");
  a_len_read: assert property (s_rd(16'h00C9) |=> reg_rdata == $past(ln_q))
    else $error("send length readback wrong");
  a_insert_cause: assert property (tx_slot_insert |-> $past(tx_slot_req))
    else $error("insert without request");
  a_run_insert: assert property (tx_slot_req && win |=> tx_slot_insert)
    else $error("slot in run not inserted");
  a_run_outside: assert property (tx_slot_req && !win |=> !tx_slot_insert)
    else $error("slot outside run inserted");
  a_byte_idle: assert property (!tx_slot_insert |-> tx_slot_byte == 8'h00)
    else $error("byte not zero when idle");
endmodule
bind backplane_ber_test_unit ber_props ber_props_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_slot_req(tx_slot_req),
  .tx_slot(tx_slot), .tx_slot_insert(tx_slot_insert), .tx_slot_byte(tx_slot_byte));

// ==== sim/ber_far_end.sv ====
`timescale 1ns/1ps
module ber_far_end
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_n,
  // Slot side
  output logic                  frame_start,
  output logic                  tx_slot_req,
  output ber_pkg::slot_t        tx_slot,
  input wire logic              tx_slot_insert,
  input wire logic [7:0]        tx_slot_byte,
  // Looped receive side
  output ber_pkg::rx_beat_t     rx_beat
);
  import ber_pkg::*;
  logic [7:0] mask;
  logic       req_q;
  slot_t      slot_q;
  initial
  begin
    frame_start = 1'b0;
    tx_slot_req = 1'b0;
    tx_slot = '0;
    mask = 8'h00;
  end
  // One frame sweeping all channels
  task frame(input logic [4:0] s, input logic [7:0] m);
    mask <= m;
    frame_start <= 1'b1;
    @(posedge sys_clk);
    frame_start <= 1'b0;
    for (int c = 0; c < 512; c++)
    begin
      tx_slot_req <= 1'b1;
      tx_slot <= {s, c[8:0]};
      @(posedge sys_clk);
    end
    tx_slot_req <= 1'b0;
    tx_slot <= ~tx_slot;
    repeat (3) @(posedge sys_clk);
  endtask
  // Loop inserted bytes back with error mask
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      req_q <= 1'b0;
      slot_q <= '0;
      rx_beat <= '0;
    end
    else
    begin
      req_q <= tx_slot_req;
      slot_q <= tx_slot;
      rx_beat <= {req_q, slot_q, req_q ? (tx_slot_insert ? tx_slot_byte ^ mask : 8'h5A) : ~rx_beat.data};
    end
endmodule

// ==== sim/backplane_ber_test_unit_tb_top.sv ====
`timescale 1ns/1ps
module backplane_ber_test_unit_tb_top;
  import ber_pkg::*;
  logic        sys_clk, rst_n, reg_wr, reg_rd, frame_start, tx_slot_req, tx_slot_insert, irq;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [7:0]  tx_slot_byte;
  slot_t       tx_slot;
  rx_beat_t    rx_beat;
  int          failures, num_checks, inserts, cycles;
  backplane_ber_test_unit backplane_ber_test_unit_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
    .tx_slot_req(tx_slot_req), .tx_slot(tx_slot), .tx_slot_insert(tx_slot_insert),
    .tx_slot_byte(tx_slot_byte), .rx_beat(rx_beat), .irq(irq));
  ber_far_end far_end_inst (.sys_clk(sys_clk), .rst_n(rst_n), .frame_start(frame_start),
    .tx_slot_req(tx_slot_req), .tx_slot(tx_slot), .tx_slot_insert(tx_slot_insert),
    .tx_slot_byte(tx_slot_byte), .rx_beat(rx_beat));
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (tx_slot_insert === 1'b1) inserts++;
    if (cycles == 30000)
    begin
      failures++;
      summarize();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rdc(input logic [15:0] a, input logic [15:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    check(v, exp);
    @(posedge sys_clk);
  endtask
  task t_reset();
    for (int a = 16'h00C8; a <= 16'h00CC; a++) rdc(a[15:0], 16'h0000);
    rdc(16'h00B2, 16'h0000);
    rdc(16'h0050, 16'h0000);
  endtask
  task t_window();
    wr(16'h00C8, 16'h0605);
    wr(16'h00C9, 16'h0003);
    wr(16'h00CA, 16'h0003);
    wr(16'h00CB, 16'h0605);
    wr(16'h00B0, 16'h0003);
    rdc(16'h00C8, 16'h0605);
    rdc(16'h00C9, 16'h0003);
    inserts = 0;
    far_end_inst.frame(5'd3, 8'h00);
    check(inserts[15:0], 16'h0004);
    rdc(16'h00CC, 16'h0000);
    inserts = 0;
    far_end_inst.frame(5'd2, 8'h00);
    check(inserts[15:0], 16'h0000);
    rdc(16'h00CC, 16'h0000);
    wr(16'h00C9, 16'h0000);
    wr(16'h00CA, 16'h0000);
    inserts = 0;
    far_end_inst.frame(5'd3, 8'h00);
    check(inserts[15:0], 16'h0001);
  endtask
  task t_errors();
    wr(16'h00B2, 16'h0007);
    wr(16'h00B3, 16'h0001);
    rdc(16'h00B3, 16'h0001);
    far_end_inst.frame(5'd3, 8'h07);
    rdc(16'h00CC, 16'h0003);
    check({15'h0000, irq}, 16'h0001);
    wr(16'h00CC, 16'hFFFF);
    rdc(16'h00CC, 16'h0003);
    wr(16'h00B2, 16'h0001);
    check({15'h0000, irq}, 16'h0000);
  endtask
  task t_saturate();
    wr(16'h00C8, 16'h0600);
    wr(16'h00C9, 16'h00FF);
    wr(16'h00CA, 16'h00FF);
    wr(16'h00CB, 16'h0600);
    repeat (33) far_end_inst.frame(5'd3, 8'hFF);
    rdc(16'h00CC, 16'hFFFF);
    rdc(16'h00B1, 16'h0007);
    wr(16'h00B0, 16'h0007);
    rdc(16'h00CC, 16'h0000);
    wr(16'h00C8, 16'h0610);
    wr(16'h00CB, 16'h0610);
    far_end_inst.frame(5'd3, 8'h00);
    rdc(16'h00CC, 16'h0000);
  endtask
  task t_midreset();
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check({15'h0000, irq}, 16'h0000);
    t_reset();
  endtask
  task summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_window();
    t_errors();
    t_saturate();
    t_midreset();
    summarize();
  end
endmodule
